// file: hw/tfp_timer16.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tfp_timer16 (
  input  wire logic                 core_clk,      // 10 MHz core clock
  input  wire logic                 sys_rst,       // sync reset, high
  input  wire logic                 timer_tick,    // prescaler tick enable
  input  wire logic [3:0]           reg_addr,      // register address
  input  wire logic [15:0]          reg_wdata,     // write data
  input  wire logic                 reg_wr,        // write strobe
  input  wire logic                 reg_rd,        // read strobe
  output logic [15:0]               reg_rdata,     // read data, cycle after strobe
  output logic                      pin_a_out,     // pin A level
  output logic                      pin_a_oe,      // pin A drive enable
  output logic                      pin_b_out,     // pin B level
  output logic                      pin_b_oe,      // pin B drive enable
  output logic [tfp_pkg::CNT_W-1:0] counter_value  // live count
);
  import tfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0]  wgm;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    logic [15:0] count;
    logic        down;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capture;
    logic [3:0]  flags;
    logic [1:0]  pin_dir;
    logic [15:0] rdata;
  } tfp_top_state_t;

  tfp_top_state_t state_ff;
  tfp_top_state_t nxt_state;

  tfp_cnt_if cnt ();

  logic        match_a;
  logic        match_b;
  logic        wave_a;
  logic        wave_b;
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic [15:0] top;
  logic [15:0] wmask;
  tfp_family_t fam;
  tfp_topsrc_t tsrc;
  logic        at_top;
  logic        at_zero;
  logic        top_event;

  ////////////////////////////////////////////////////////////////////////////
  assign fam  = mode_family(state_ff.wgm);
  assign tsrc = top_source(state_ff.wgm);

  always_comb begin
    unique case (tsrc)
      TFP_TOP_CAP:  top = state_ff.capture;
      TFP_TOP_CMPA: top = act_a;
      default:      top = fixed_top(state_ff.wgm);
    endcase
  end

  // fixed tops are all-ones patterns, so the top itself is the mask
  assign wmask = (tsrc == TFP_TOP_FIXED && fam != TFP_FAM_NONE)
                 ? fixed_top(state_ff.wgm) : CNT_MAX;

  assign at_top  = (state_ff.count == top) && (fam != TFP_FAM_NONE);
  assign at_zero = (state_ff.count == CNT_ZERO);
  assign top_event = timer_tick && at_top;

  assign cnt.tick          = timer_tick;
  assign cnt.family        = fam;
  assign cnt.count         = state_ff.count;
  assign cnt.counting_down = state_ff.down;
  assign cnt.at_top        = at_top;
  assign cnt.at_zero       = at_zero;
  assign cnt.wrap          = (fam == TFP_FAM_FAST) && at_zero;

  ////////////////////////////////////////////////////////////////////////////
  tfp_channel u_chan_a (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .cnt          (cnt),
    .buf_value    (state_ff.buf_a),
    .out_mode     (state_ff.com_a),
    .active_value (act_a),
    .match        (match_a),
    .wave         (wave_a)
  );

  tfp_channel u_chan_b (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .cnt          (cnt),
    .buf_value    (state_ff.buf_b),
    .out_mode     (state_ff.com_b),
    .active_value (act_b),
    .match        (match_b),
    .wave         (wave_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.rdata = RST_WORD;

    // counter
    if (timer_tick) begin
      unique case (fam)
        TFP_FAM_FAST: begin
          nxt_state.down = 1'b0;
          if (at_top) begin
            nxt_state.count = CNT_ZERO;
          end else begin
            // a top written below the count wraps through max
            nxt_state.count = state_ff.count + 16'h0001;
          end
        end
        TFP_FAM_PHASE: begin
          if (at_top) begin
            nxt_state.down  = 1'b1;
            nxt_state.count = state_ff.count - 16'h0001;
          end else if (state_ff.down && !at_zero) begin
            nxt_state.count = state_ff.count - 16'h0001;
          end else begin
            nxt_state.down  = 1'b0;
            nxt_state.count = state_ff.count + 16'h0001;
          end
        end
        default: begin
          // outside the pwm modes the counter holds
          nxt_state.down = 1'b0;
        end
      endcase
    end

    // flags: hardware set wins over software clear
    if (reg_wr && reg_addr == ADDR_FLAGS) begin
      nxt_state.flags = state_ff.flags & ~reg_wdata[3:0];
    end
    if (match_a) nxt_state.flags[FLG_CMA] = 1'b1;
    if (match_b) nxt_state.flags[FLG_CMB] = 1'b1;
    if (fam == TFP_FAM_FAST && top_event) begin
      nxt_state.flags[FLG_OVF] = 1'b1;
    end
    if (fam == TFP_FAM_PHASE && timer_tick && at_zero) begin
      nxt_state.flags[FLG_OVF] = 1'b1;
    end
    if (top_event && tsrc == TFP_TOP_CAP) begin
      nxt_state.flags[FLG_CAP] = 1'b1;
    end
    if (top_event && tsrc == TFP_TOP_CMPA) begin
      nxt_state.flags[FLG_CMA] = 1'b1;
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: begin
          nxt_state.wgm   = reg_wdata[CTRL_WGM_LSB +: 4];
          nxt_state.com_a = reg_wdata[CTRL_COMA_LSB +: 2];
          nxt_state.com_b = reg_wdata[CTRL_COMB_LSB +: 2];
        end
        ADDR_COUNT:   nxt_state.count   = reg_wdata;
        ADDR_CMP_A:   nxt_state.buf_a   = reg_wdata & wmask;
        ADDR_CMP_B:   nxt_state.buf_b   = reg_wdata & wmask;
        ADDR_CAPTURE: nxt_state.capture = reg_wdata;
        ADDR_PIN_DIR: nxt_state.pin_dir = reg_wdata[1:0];
        default:      nxt_state.pin_dir = nxt_state.pin_dir;
      endcase
    end

    // register reads, unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:    nxt_state.rdata = {8'h00, state_ff.com_b, state_ff.com_a, state_ff.wgm};
        ADDR_COUNT:   nxt_state.rdata = state_ff.count;
        ADDR_CMP_A:   nxt_state.rdata = state_ff.buf_a;
        ADDR_CMP_B:   nxt_state.rdata = state_ff.buf_b;
        ADDR_CAPTURE: nxt_state.rdata = state_ff.capture;
        ADDR_FLAGS:   nxt_state.rdata = {12'h000, state_ff.flags};
        ADDR_PIN_DIR: nxt_state.rdata = {14'h0000, state_ff.pin_dir};
        default:      nxt_state.rdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff     <= '0;
      state_ff.wgm <= RST_WGM;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata     = state_ff.rdata;
  assign counter_value = state_ff.count;
  // override only when a mode is set; direction still gates the pin
  assign pin_a_out = wave_a && (state_ff.com_a != COM_OFF);
  assign pin_a_oe  = state_ff.pin_dir[0];
  assign pin_b_out = wave_b && (state_ff.com_b != COM_OFF);
  assign pin_b_oe  = state_ff.pin_dir[1];

endmodule : tfp_timer16

`default_nettype wire

// file: hw/tfp_pkg.sv
package tfp_pkg;

  localparam int unsigned CNT_W = 16;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_COUNT    = 4'h1;
  localparam logic [3:0] ADDR_CMP_A    = 4'h2;
  localparam logic [3:0] ADDR_CMP_B    = 4'h3;
  localparam logic [3:0] ADDR_CAPTURE  = 4'h4;
  localparam logic [3:0] ADDR_FLAGS    = 4'h5;
  localparam logic [3:0] ADDR_PIN_DIR  = 4'h6;

  // ctrl field layout
  localparam int unsigned CTRL_WGM_LSB  = 0;
  localparam int unsigned CTRL_COMA_LSB = 4;
  localparam int unsigned CTRL_COMB_LSB = 6;

  // flags field layout
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMA = 1;
  localparam int unsigned FLG_CMB = 2;
  localparam int unsigned FLG_CAP = 3;

  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] MIN_TOP   = 16'h0003;

  localparam logic [3:0]  RST_WGM   = 4'h0;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV    = 2'h3;

  typedef enum logic [1:0] {
    TFP_FAM_NONE = 2'b00,
    TFP_FAM_FAST = 2'b01,
    TFP_FAM_PHASE = 2'b10
  } tfp_family_t;

  typedef enum logic [1:0] {
    TFP_TOP_FIXED = 2'b00,
    TFP_TOP_CAP   = 2'b01,
    TFP_TOP_CMPA  = 2'b10
  } tfp_topsrc_t;

  // maps a waveform mode to its family
  function automatic tfp_family_t mode_family(input logic [3:0] m);
    case (m)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_family = TFP_FAM_FAST;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_family = TFP_FAM_PHASE;
      default:                      mode_family = TFP_FAM_NONE;
    endcase
  endfunction

  // fixed top for modes 1..3 and 5..7, else max
  function automatic logic [15:0] fixed_top(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: fixed_top = TOP_8BIT;
      4'h2, 4'h6: fixed_top = TOP_9BIT;
      4'h3, 4'h7: fixed_top = TOP_10BIT;
      default:    fixed_top = CNT_MAX;
    endcase
  endfunction

  function automatic tfp_topsrc_t top_source(input logic [3:0] m);
    case (m)
      4'hA, 4'hE: top_source = TFP_TOP_CAP;
      4'hB, 4'hF: top_source = TFP_TOP_CMPA;
      default:    top_source = TFP_TOP_FIXED;
    endcase
  endfunction

endpackage : tfp_pkg

// file: hw/tfp_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none

// counter state shared with the compare channels
interface tfp_cnt_if;
  import tfp_pkg::*;
  logic          tick;
  tfp_family_t   family;
  logic [15:0]   count;
  logic          counting_down;
  logic          at_top;
  logic          at_zero;
  logic          wrap;

  modport counter (output tick, family, count, counting_down, at_top, at_zero, wrap);
  modport channel (input  tick, family, count, counting_down, at_top, at_zero, wrap);
endinterface : tfp_cnt_if

`default_nettype wire

// file: hw/tfp_channel.sv
`timescale 1ns/1ps
`default_nettype none

// one compare channel: buffer, match, waveform flop
module tfp_channel (
  input  wire logic          core_clk,    // core clock
  input  wire logic          sys_rst,     // sync reset, high
  tfp_cnt_if.channel         cnt,         // counter state
  input  wire logic [15:0]   buf_value,   // software-written buffer
  input  wire logic [1:0]    out_mode,    // compare output mode
  output logic [15:0]        active_value,// compare value in use
  output logic               match,       // tick-qualified match
  output logic               wave         // internal compare output
);
  import tfp_pkg::*;

  typedef struct packed {
    logic [15:0] act;
    logic        wave;
  } tfp_ch_state_t;

  tfp_ch_state_t state_ff;
  tfp_ch_state_t nxt_state;

  logic eq;

  assign eq           = (cnt.count == state_ff.act);
  assign match        = cnt.tick && eq && (cnt.family != TFP_FAM_NONE);
  assign active_value = state_ff.act;
  assign wave         = state_ff.wave;

  always_comb begin
    nxt_state = state_ff;
    if (cnt.tick) begin
      // buffered value lands at top in both families
      if (cnt.at_top) begin
        nxt_state.act = buf_value;
      end
      unique case (cnt.family)
        TFP_FAM_FAST: begin
          if (eq) begin
            unique case (out_mode)
              COM_TOGGLE: nxt_state.wave = ~state_ff.wave;
              COM_NONINV: nxt_state.wave = 1'b0;
              COM_INV:    nxt_state.wave = 1'b1;
              COM_OFF:    nxt_state.wave = state_ff.wave;
            endcase
          end
          // bottom action lands on the top tick, as the count clears;
          // it wins over a match at top so compare==top gives a steady level
          if (cnt.at_top && out_mode[1]) begin
            nxt_state.wave = (out_mode == COM_NONINV);
          end
        end
        TFP_FAM_PHASE: begin
          // at top the direction flag is still up; matches at top and zero hold the level
          if (eq && (out_mode == COM_NONINV)) begin
            nxt_state.wave = cnt.counting_down;
          end else if (eq && (out_mode == COM_INV)) begin
            nxt_state.wave = ~cnt.counting_down;
          end
          if (eq && (cnt.count == CNT_ZERO)) begin
            nxt_state.wave = (out_mode == COM_INV);
          end
          if (eq && cnt.at_top && out_mode[1]) begin
            nxt_state.wave = (out_mode == COM_NONINV);
          end
          if (out_mode[1] == 1'b0) begin
            nxt_state.wave = state_ff.wave;
          end
        end
        default: nxt_state = nxt_state;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : tfp_channel

`default_nettype wire

// file: sim/tfp_timer16_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module tfp_timer16_asserts (
  input wire logic        core_clk,      // clock
  input wire logic        sys_rst,       // sync reset
  input wire logic        timer_tick,    // tick enable
  input wire logic [3:0]  reg_addr,      // address
  input wire logic [15:0] reg_wdata,     // write data
  input wire logic        reg_wr,        // write strobe
  input wire logic        reg_rd,        // read strobe
  input wire logic [15:0] reg_rdata,     // read data
  input wire logic        pin_a_out,     // pin A level
  input wire logic        pin_a_oe,      // pin A enable
  input wire logic        pin_b_out,     // pin B level
  input wire logic        pin_b_oe,      // pin B enable
  input wire logic [15:0] counter_value  // live count
);
  import tfp_pkg::*;
  logic [3:0]  mode_ff;
  logic [15:0] ftop;
  logic        step, f_top, f_below, p_top, p_zero;
  // shadow of the mode field, updated on the same edge as the design
  always_ff @(posedge core_clk) begin
    if (sys_rst) mode_ff <= RST_WGM;
    else if (reg_wr && reg_addr == ADDR_CTRL) mode_ff <= reg_wdata[3:0];
  end
  assign ftop    = (mode_ff[1:0] == 2'h1) ? TOP_8BIT : (mode_ff[1:0] == 2'h2) ? TOP_9BIT : TOP_10BIT;
  // counter writes win over a tick, so those cycles are left out
  assign step    = timer_tick && !reg_wr;
  assign f_top   = step && (mode_ff inside {4'h5, 4'h6, 4'h7}) && counter_value == ftop;
  assign f_below = step && (mode_ff inside {4'h5, 4'h6, 4'h7}) && counter_value < ftop;
  assign p_top   = step && (mode_ff inside {4'h1, 4'h2, 4'h3}) && counter_value == ftop;
  assign p_zero  = step && (mode_ff inside {4'h1, 4'h2, 4'h3}) && counter_value == CNT_ZERO;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == RST_WORD)
    else $error("read data not idle");
  chk_dir_read: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_PIN_DIR |->
    reg_rdata == {14'h0, $past(pin_b_oe), $past(pin_a_oe)}) else $error("direction readback");
  chk_dir_gate: assert property ($past(reg_wr) && $past(reg_addr) == ADDR_PIN_DIR |->
    pin_a_oe == $past(reg_wdata[0]) && pin_b_oe == $past(reg_wdata[1])) else $error("pin enable");
  chk_tick_gate: assert property (!$past(timer_tick) && !$past(reg_wr) |-> $stable(counter_value))
    else $error("count moved without tick");
  chk_fast_wrap: assert property ($past(f_top) |-> counter_value == CNT_ZERO)
    else $error("fast wrap");
  chk_fast_step: assert property ($past(f_below) |-> counter_value == $past(counter_value) + 16'h1)
    else $error("fast increment");
  chk_phase_turn: assert property (p_top |=> counter_value == $past(ftop) - 16'h1)
    else $error("dual slope turn");
  chk_phase_floor: assert property (p_zero |=> counter_value == 16'h0001)
    else $error("dual slope floor");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |=>
    !pin_a_out && !pin_b_out && counter_value == CNT_ZERO) else $error("reset state");
  cover property (f_top);
  cover property (p_top);
  cover property (pin_a_oe && pin_a_out);
endmodule // tfp_timer16_asserts

bind tfp_timer16 tfp_timer16_asserts chk_u (.core_clk, .sys_rst, .timer_tick, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe,
  .counter_value);

`default_nettype wire

// file: sim/tfp_timer16_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tfp_timer16_tb;
  import tfp_pkg::*;
  localparam logic [15:0] CAPV = 16'h0009;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        timer_tick = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, counter_value;
  logic        pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  int          errors = 0;
  int          samples_checked = 0;
  logic [15:0] cnt, bufa, bufb, acta = 16'h0, actb = 16'h0;
  logic        wa = 1'b0, wb = 1'b0, up = 1'b1;
  logic [3:0]  flg, md;
  logic [1:0]  ca, cb;
  // compares kept at or below every top in use; modes F and B move top while running
  logic [3:0]  t_md [10] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
  logic [3:0]  t_com [10] = '{4'hE, 4'hB, 4'h1, 4'hE, 4'h9, 4'hE, 4'hB, 4'h8, 4'hE, 4'hB};
  logic [15:0] t_ca [10] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h4, 16'h7, 16'h0, 16'h0, 16'h0,
                             16'h5, 16'h8};
  logic [15:0] t_cb [10] = '{16'h0, 16'h0, 16'h0, 16'h9, 16'h3, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                             16'h2, 16'h4};

  always #50 core_clk = ~core_clk;

  tfp_timer16 dut_u (.core_clk, .sys_rst, .timer_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .counter_value);

  ////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #10;
    check(nm, reg_rdata, exp);
    @(posedge core_clk);
  endtask

  function automatic logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: return TOP_8BIT;
      4'h2, 4'h6: return TOP_9BIT;
      4'h3, 4'h7: return TOP_10BIT;
      4'hA, 4'hE: return CAPV;
      default:    return acta;
    endcase
  endfunction

  // next compare output state for one tick, from the count before the tick
  function automatic logic wave(input logic w, input logic [1:0] c, input logic [15:0] cv, p, t,
                                input logic f, u);
    if (c == COM_TOGGLE) return (f && p == cv) ? !w : w;
    if (c == COM_OFF) return w;
    if (f) begin
      if (p == t) return c == COM_NONINV;
      if (p == cv) return c == COM_INV;
      return w;
    end
    if (p != cv) return w;
    return (c == COM_NONINV) ~^ ((cv == t) || (cv != 16'h0 && !u));
  endfunction

  // ticks are spaced out so counter and pins have settled when compared
  task automatic tick1(input logic f);
    logic [15:0] p, t;
    p = cnt;
    t = top_of(md);
    wa = wave(wa, ca, acta, p, t, f, up);
    wb = wave(wb, cb, actb, p, t, f, up);
    flg |= {(md == 4'hE || md == 4'hA) && p == t, p == actb, p == acta, f ? p == t : p == 16'h0};
    if (f) cnt = (p == t) ? 16'h0 : p + 16'h1;
    else if (up) cnt = (p == t) ? p - 16'h1 : p + 16'h1;
    else cnt = (p == 16'h0) ? 16'h1 : p - 16'h1;
    if (!f) up = up ? (p != t) : (p == 16'h0);
    if (p == t) begin
      acta = bufa;
      actb = bufb;
    end
    timer_tick <= 1'b1;
    @(posedge core_clk);
    timer_tick <= 1'b0;
    repeat (3) @(posedge core_clk);
    #10;
    check("count", counter_value, cnt);
    check("pin_a", {15'h0, pin_a_out}, {15'h0, ca != COM_OFF && wa});
    check("pin_b", {15'h0, pin_b_out}, {15'h0, cb != COM_OFF && wb});
    @(posedge core_clk);
  endtask

  ////////////////////////////////////////
  // budget: about 2000 ticks of five cycles plus register traffic
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    stop_test;
  end

  initial begin
    int n;
    logic f, fix;
    logic [15:0] top;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 8; a++) rdc(a[3:0], RST_WORD, "reset_reg");
    check("reset_pins", {14'h0, pin_a_out, pin_b_out}, 16'h0);
    wr(ADDR_PIN_DIR, 16'h0003);
    rdc(ADDR_PIN_DIR, 16'h0003, "pin_dir");
    check("pin_oe", {14'h0, pin_b_oe, pin_a_oe}, 16'h0003);
    for (int i = 0; i < 10; i++) begin
      md = t_md[i];
      ca = t_com[i][1:0];
      cb = t_com[i][3:2];
      f = md[2];
      fix = !md[3];
      wr(ADDR_CTRL, {8'h00, t_com[i], md});
      wr(ADDR_CAPTURE, CAPV);
      top = top_of(md);
      bufa = t_ca[i] & (fix ? top : CNT_MAX);
      bufb = t_cb[i] & (fix ? top : CNT_MAX);
      wr(ADDR_CMP_A, t_ca[i]);
      wr(ADDR_CMP_B, t_cb[i]);
      rdc(ADDR_CMP_A, bufa, "cmp_a");
      rdc(ADDR_CMP_B, bufb, "cmp_b");
      cnt = (md == 4'hE) ? 16'hFFFD : (f && fix) ? top - 16'h5 : 16'h0;
      wr(ADDR_COUNT, cnt);
      wr(ADDR_FLAGS, 16'h000F);
      flg = 4'h0;
      n = f ? 20 : fix ? int'(top) + 20 : 30;
      repeat (n) tick1(f);
      rdc(ADDR_FLAGS, {12'h0, flg}, "flags");
    end
    wr(ADDR_PIN_DIR, 16'h0000);
    check("pin_oe_off", {14'h0, pin_b_oe, pin_a_oe}, 16'h0000);
    stop_test;
  end
endmodule // tfp_timer16_tb

`default_nettype wire
